// ---- bench/cpf_coproc_assertions.sv ----
module cpf_coproc_assertions (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic fetch_request_n_in,
  input wire logic stall_input_n_in,
  input wire logic cond_pass_in,
  input wire logic busy_in,
  input wire logic [1:0] decode_handshake_out,
  input wire logic [1:0] execute_handshake_out,
  input wire logic read_data_input_bus_oe_out,
  input wire logic commit_out,
  input wire logic abandon_out,
  input wire logic busy_wait_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!reset_n_in);
  wire adv = stall_input_n_in && !fetch_request_n_in;
  sequence s_quit;
    abandon_out && execute_handshake_out == 2'h2;
  endsequence
  a_oe_after_entry: assert property (
    $rose(read_data_input_bus_oe_out) |-> $past(adv, 2) || $past(adv, 3))
    else $error("bus drive without entry");
  a_oe_release: assert property (
    read_data_input_bus_oe_out && adv |=> !read_data_input_bus_oe_out)
    else $error("bus drive kept past advance");
  a_dwait_busy: assert property (
    decode_handshake_out == 2'h0 |-> $past(busy_in))
    else $error("decode wait while not busy");
  a_drop_abandon: assert property (
    busy_wait_out && !cond_pass_in |=> abandon_out)
    else $error("no abandon on pass low");
  a_drop_quits: assert property (
    busy_wait_out && !cond_pass_in |=> s_quit)
    else $error("handshake not absent after abandon");
  a_commit_pass: assert property (
    commit_out |-> cond_pass_in || $past(cond_pass_in))
    else $error("commit without pass");
  a_dec_hold: assert property (
    !adv && !$past(adv) && $stable(busy_in) |=> $stable(decode_handshake_out))
    else $error("decode moved while stalled");
  a_go_next: assert property (
    execute_handshake_out == 2'h1 && cond_pass_in && !busy_in && !adv
    |=> execute_handshake_out inside {2'h1, 2'h3})
    else $error("go not followed by go or last");
endmodule

bind cpf_coproc cpf_coproc_assertions u_chk (
  .ref_clk_in, .reset_n_in, .fetch_request_n_in, .stall_input_n_in,
  .cond_pass_in, .busy_in, .decode_handshake_out, .execute_handshake_out,
  .read_data_input_bus_oe_out, .commit_out, .abandon_out, .busy_wait_out
);

// ---- bench/cpf_coproc_tb.sv ----
module cpf_coproc_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic busy_in = 1'b0;
  int failures;
  int cmp_count;
  wire fr_n, st_n, cp, ak, dm_n, oe, cmt, abn, bw;
  wire [31:0] ibus, wd, rd, rdo;
  wire [1:0] dhs, ehs;
  cpf_coproc u_cpf_coproc (
    .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .fetch_request_n_in(fr_n),
    .stall_input_n_in(st_n), .instruction_data_bus_in(ibus), .cond_pass_in(cp),
    .abort_kill_in(ak), .data_memory_request_n_in(dm_n), .write_data_output_bus_in(wd),
    .read_data_input_bus_in(rd), .busy_in(busy_in), .decode_handshake_out(dhs),
    .execute_handshake_out(ehs), .read_data_input_bus_out(rdo),
    .read_data_input_bus_oe_out(oe), .commit_out(cmt), .abandon_out(abn),
    .busy_wait_out(bw)
  );
  cpf_core_model u_cpf_core_model (
    .ref_clk_in(ref_clk_in), .decode_handshake_in(dhs), .execute_handshake_in(ehs),
    .bus_drive_in(rdo), .bus_oe_in(oe), .fetch_request_n_out(fr_n),
    .stall_input_n_out(st_n), .instruction_data_bus_out(ibus), .cond_pass_out(cp),
    .abort_kill_out(ak), .data_memory_request_n_out(dm_n),
    .write_data_output_bus_out(wd), .read_data_input_bus_out(rd)
  );
  always #4 ref_clk_in = ~ref_clk_in;
  function automatic logic [31:0] cpi(input logic [3:0] op, input logic [2:0] x,
      input logic l, input logic [3:0] n, input logic [3:0] d, input logic [3:0] m,
      input logic [3:0] cpn, input logic mv);
    return {4'hE, op, x, l, n, d, cpn, 3'h0, mv, m};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic issue(input logic [31:0] x, input int n);
    u_cpf_core_model.adv(x);
    u_cpf_core_model.adv(32'h0);
    u_cpf_core_model.adv(32'h0);
    repeat (n) @(negedge ref_clk_in);
  endtask
  task automatic t_reset;
    chk({dhs, ehs, oe}, 5'h14);
  endtask
  task automatic t_math;
    u_cpf_core_model.wd = 32'h12340A05;
    issue(cpi(4'hE, 3'h0, 1'b0, 4'h1, 4'h1, 4'h1, 4'hA, 1'b1), 4);
    issue(cpi(4'hE, 3'h0, 1'b0, 4'h1, 4'h3, 4'h1, 4'hA, 1'b0), 4);
    issue(cpi(4'hE, 3'h0, 1'b1, 4'h3, 4'h3, 4'h3, 4'hA, 1'b1), 4);
    chk({oe, rdo}, {1'b1, 32'h2468140A});
  endtask
  task automatic t_foreign;
    int u0;
    u0 = u_cpf_core_model.undef_cnt;
    issue(cpi(4'hE, 3'h0, 1'b0, 4'h1, 4'h3, 4'h1, 4'h3, 1'b0), 4);
    chk(u_cpf_core_model.undef_cnt, u0 + 1);
  endtask
  task automatic t_busy;
    logic seen;
    seen = 1'b0;
    busy_in = 1'b1;
    issue(cpi(4'hE, 3'h0, 1'b0, 4'h3, 4'h3, 4'h3, 4'hA, 1'b0), 3);
    chk({bw, ehs}, 3'h4);
    u_cpf_core_model.pass = 1'b0;
    repeat (8) begin
      @(negedge ref_clk_in);
      seen = seen | abn;
    end
    chk(seen, 1'b1);
    busy_in = 1'b0;
    u_cpf_core_model.pass = 1'b1;
    issue(cpi(4'hE, 3'h0, 1'b1, 4'h3, 4'h3, 4'h3, 4'hA, 1'b1), 4);
    chk(rdo, 32'h2468140A);
    busy_in = 1'b1;
    issue(cpi(4'hE, 3'h0, 1'b0, 4'h3, 4'h4, 4'h1, 4'hA, 1'b0), 2);
    busy_in = 1'b0;
    repeat (4) @(negedge ref_clk_in);
    chk({bw, ehs}, 3'h2);
    issue(cpi(4'hE, 3'h0, 1'b1, 4'h4, 4'h4, 4'h4, 4'hA, 1'b1), 4);
    chk(rdo, 32'h369C1E0F);
  endtask
  task automatic t_kill;
    u_cpf_core_model.kill = 1'b1;
    issue(cpi(4'hE, 3'h0, 1'b0, 4'h3, 4'h3, 4'h3, 4'hA, 1'b0), 4);
    u_cpf_core_model.kill = 1'b0;
    issue(cpi(4'hE, 3'h0, 1'b1, 4'h3, 4'h3, 4'h3, 4'hA, 1'b1), 4);
    chk(rdo, 32'h2468140A);
  endtask
  task automatic t_burst;
    u_cpf_core_model.ld_val = 32'h5A5A0F0F;
    u_cpf_core_model.n_go = 0;
    u_cpf_core_model.n_last = 0;
    issue(cpi(4'hD, 3'h6, 1'b1, 4'h0, 4'h4, 4'h0, 4'hA, 1'b0), 10);
    chk(u_cpf_core_model.n_go, 2);
    chk(u_cpf_core_model.n_last, 1);
    issue(cpi(4'hE, 3'h0, 1'b1, 4'h7, 4'h7, 4'h7, 4'hA, 1'b1), 4);
    chk(rdo, 32'h5A5A0F0F);
    issue(cpi(4'hE, 3'h0, 1'b1, 4'h4, 4'h4, 4'h4, 4'hA, 1'b1), 4);
    chk(rdo, 32'h5A5A0F0F);
    issue(cpi(4'hC, 3'h0, 1'b0, 4'h0, 4'h4, 4'h0, 4'hA, 1'b0), 4);
    chk({oe, rdo}, {1'b1, 32'h5A5A0F0F});
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge ref_clk_in);
    reset_n_in = 1'b1;
    t_reset();
    t_math();
    t_foreign();
    t_busy();
    t_kill();
    t_burst();
    summarize();
  end
  initial begin
    #20000;
    failures++;
    summarize();
  end
endmodule

// ---- bench/cpf_core_model.sv ----
module cpf_core_model (
  input wire logic ref_clk_in,
  input wire logic [1:0] decode_handshake_in,
  input wire logic [1:0] execute_handshake_in,
  input wire logic [31:0] bus_drive_in,
  input wire logic bus_oe_in,
  output logic fetch_request_n_out,
  output logic stall_input_n_out,
  output logic [31:0] instruction_data_bus_out,
  output logic cond_pass_out,
  output logic abort_kill_out,
  output logic data_memory_request_n_out,
  output logic [31:0] write_data_output_bus_out,
  output logic [31:0] read_data_input_bus_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] nxt = 32'h0, f = 32'h0, d = 32'h0, e = 32'h0;
  logic [31:0] ld_val = 32'h0, wd = 32'h0;
  logic pass = 1'b1, kill = 1'b0;
  logic kill_due = 1'b0;
  int undef_cnt, n_go, n_last;
  function automatic logic is_cp(input logic [31:0] x);
    return x[27:24] == 4'hE || x[27:25] == 3'h6;
  endfunction
  initial begin
    fetch_request_n_out = 1'b1;
    stall_input_n_out = 1'b1;
    instruction_data_bus_out = 32'h0;
    abort_kill_out = 1'b0;
  end
  assign cond_pass_out = pass && is_cp(e);
  assign data_memory_request_n_out = !(e[27:25] == 3'h6);
  assign write_data_output_bus_out = wd;
  assign read_data_input_bus_out = bus_oe_in ? bus_drive_in : ld_val;
  // advance and cancel
  // The cancel stands for one cycle, one cycle after the instruction enters execute.
  always @(negedge ref_clk_in) begin
    abort_kill_out <= kill_due;
    kill_due <= 1'b0;
    if (!fetch_request_n_out && stall_input_n_out) begin
      e <= d;
      d <= f;
      f <= nxt;
      kill_due <= kill && is_cp(d);
    end
  end
  always @(posedge ref_clk_in) begin
    if (!fetch_request_n_out && stall_input_n_out && is_cp(d) && decode_handshake_in == 2'h2) begin
      undef_cnt++;
    end
    if (is_cp(e) && execute_handshake_in == 2'h1) begin
      n_go++;
    end
    if (is_cp(e) && execute_handshake_in == 2'h3) begin
      n_last++;
    end
  end
  task automatic adv(input logic [31:0] x);
    @(negedge ref_clk_in);
    fetch_request_n_out <= 1'b0;
    stall_input_n_out <= 1'b0;
    nxt <= x;
    @(negedge ref_clk_in);
    stall_input_n_out <= 1'b1;
    @(negedge ref_clk_in);
    fetch_request_n_out <= 1'b1;
    instruction_data_bus_out <= x;
    @(negedge ref_clk_in);
    instruction_data_bus_out <= ~x;
  endtask
endmodule

// ---- rtl/cpf_consts.svh ----
`ifndef CPF_CONSTS_SVH
`define CPF_CONSTS_SVH

// Handshake codes on both the decode and execute handshake buses.
`define CPF_HS_WAIT 2'h0
`define CPF_HS_GO 2'h1
`define CPF_HS_ABSENT 2'h2
`define CPF_HS_LAST 2'h3

// Coprocessor number this unit answers to.
`define CPF_CP_NUM 4'hA

// Instruction field positions.
`define CPF_CPN_HI 11
`define CPF_CPN_LO 8
`define CPF_OP_HI 27
`define CPF_OP4_LO 24
`define CPF_OP3_LO 25
`define CPF_LOAD_BIT 20
`define CPF_LONG_BIT 22
`define CPF_MOVE_BIT 4
`define CPF_CRN_LO 16
`define CPF_CRD_LO 12
`define CPF_CRM_LO 0

// Opcode groups and word counts.
`define CPF_OP_DATA 4'hE
`define CPF_OP_LDST 3'h6
`define CPF_WORDS_LONG 4'h4
`define CPF_WORDS_ONE 4'h1
`define CPF_WORDS_NONE 4'h0

`endif

// ---- rtl/cpf_coproc.sv ----
`include "cpf_consts.svh"

module cpf_coproc
  import cpf_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic fetch_request_n_in,
  input wire logic stall_input_n_in,
  input wire logic [31:0] instruction_data_bus_in,
  input wire logic cond_pass_in,
  input wire logic abort_kill_in,
  input wire logic data_memory_request_n_in,
  input wire logic [31:0] write_data_output_bus_in,
  input wire logic [31:0] read_data_input_bus_in,
  input wire logic busy_in,
  output logic [1:0] decode_handshake_out,
  output logic [1:0] execute_handshake_out,
  output logic [31:0] read_data_input_bus_out,
  output logic read_data_input_bus_oe_out,
  output logic commit_out,
  output logic abandon_out,
  output logic busy_wait_out
);

  logic adv;
  logic [31:0] dc_instr;
  cpf_cls_t dc_cls;
  logic dc_mine;
  logic [3:0] dc_words;

  cpf_follower u_follower (
    .ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .fetch_request_n_in(fetch_request_n_in),
    .stall_input_n_in(stall_input_n_in),
    .instruction_data_bus_in(instruction_data_bus_in),
    .adv_out(adv),
    .dec_instr_out(dc_instr)
  );

  cpf_decoder u_decoder (
    .instr_in(dc_instr),
    .cls_out(dc_cls),
    .mine_out(dc_mine),
    .words_out(dc_words)
  );

  // Coprocessor register file, written the cycle after each load, move-in or data-operation transfer unless abandoned in that cycle.
  logic [31:0] rf [16];

  cpf_st_t st_q;
  cpf_st_t st_d;
  cpf_cls_t cls_q;
  cpf_cls_t cls_d;
  cpf_hs_t dhs_q;
  cpf_hs_t dhs_d;
  cpf_hs_t ehs_q;
  cpf_hs_t ehs_d;
  logic [3:0] rem_q;
  logic [3:0] rem_d;
  logic [3:0] idx_q;
  logic [3:0] idx_d;
  logic [3:0] crn_q;
  logic [3:0] crn_d;
  logic [3:0] crd_q;
  logic [3:0] crd_d;
  logic [3:0] crm_q;
  logic [3:0] crm_d;
  logic xfer_q;
  logic xfer_d;
  logic ent_q;
  logic ent_d;
  logic first_q;
  logic first_d;
  logic wb_v_q;
  logic wb_v_d;
  logic [3:0] wb_a_q;
  logic [3:0] wb_a_d;
  logic [31:0] wb_q;
  logic [31:0] wb_d;
  logic own_q;
  logic own_d;
  logic [31:0] rd_q;
  logic [31:0] rd_d;
  logic cmt_q;
  logic cmt_d;
  logic abn_q;
  logic abn_d;
  logic bw_q;
  logic bw_d;
  logic kill;
  logic drop;
  logic abn;
  logic accept;
  logic [3:0] rd_a;

  always_comb begin
    st_d = st_q;
    cls_d = cls_q;
    rem_d = rem_q;
    idx_d = idx_q;
    crn_d = crn_q;
    crd_d = crd_q;
    crm_d = crm_q;
    xfer_d = 1'b0;
    ent_d = 1'b0;
    wb_v_d = 1'b0;
    wb_a_d = wb_a_q;
    wb_d = wb_q;
    own_d = own_q;
    cmt_d = 1'b0;
    abn_d = 1'b0;
    first_d = ent_q;

    kill = first_q && abort_kill_in;
    drop = (st_q != ST_IDLE) && !cond_pass_in;
    abn = kill || drop;

    accept = ((st_q == ST_WAIT) || (st_q == ST_RUN)) && !abn
      && ((ehs_q == HS_GO) || (ehs_q == HS_LAST));

    if (accept) begin
      rem_d = 4'(rem_q - 4'h1);
      xfer_d = 1'b1;
      st_d = (rem_q == 4'h1) ? ST_FIN : ST_RUN;
    end else if (st_q == ST_FIN) begin
      st_d = ST_IDLE;
      cmt_d = !abn;
    end
    if (abn && (st_q != ST_IDLE)) begin
      st_d = ST_IDLE;
      rem_d = 4'h0;
      xfer_d = 1'b0;
      cmt_d = 1'b0;
    end
    abn_d = abn;

    // Transfer cycle: stage the write so a late cancel can still drop it.
    if (xfer_q && !abn) begin
      idx_d = 4'(idx_q + 4'h1);
      case (cls_q)
        CLS_LOAD: begin
          // The core lowers its data request in the transfer cycle itself.
          // request in transfer
          wb_v_d = !data_memory_request_n_in;
          wb_a_d = cpf_addr(crd_q, idx_q);
          wb_d = read_data_input_bus_in;
        end
        CLS_MV_IN: begin
          wb_v_d = 1'b1;
          wb_a_d = crn_q;
          wb_d = write_data_output_bus_in;
        end
        CLS_DOP: begin
          wb_v_d = 1'b1;
          wb_a_d = crd_q;
          wb_d = 32'(rf[crn_q] + rf[crm_q]);
        end
        default: begin
          wb_v_d = 1'b0;
        end
      endcase
    end

    if (ent_q && ((cls_q == CLS_MV_OUT) || (cls_q == CLS_STORE))) begin
      own_d = 1'b1;
    end

    if (adv) begin
      own_d = 1'b0;
      idx_d = 4'h0;
      cls_d = dc_mine ? dc_cls : CLS_NONE;
      crn_d = dc_instr[`CPF_CRN_LO +: 4];
      crd_d = dc_instr[`CPF_CRD_LO +: 4];
      crm_d = dc_instr[`CPF_CRM_LO +: 4];
      rem_d = 4'h0;
      xfer_d = 1'b0;
      st_d = ST_IDLE;
      if (dc_mine) begin
        ent_d = 1'b1;
        // waits before the first go or last
        if (dhs_q == HS_WAIT) begin
          st_d = ST_WAIT;
          rem_d = dc_words;
        end else begin
          rem_d = 4'(dc_words - 4'h1);
          xfer_d = 1'b1;
          st_d = (dc_words == 4'h1) ? ST_FIN : ST_RUN;
        end
      end
    end

    dhs_d = dc_mine ? cpf_hs_pick(dc_words, busy_in) : HS_ABSENT;
    if (st_d == ST_WAIT) begin
      ehs_d = cpf_hs_pick(rem_d, busy_in);
    end else if (st_d == ST_RUN) begin
      ehs_d = cpf_hs_pick(rem_d, 1'b0);
    end else begin
      ehs_d = HS_ABSENT;
    end
    bw_d = (st_d == ST_WAIT);

    // Read data for moves out comes from CRn; for stores it follows the word index.
    rd_a = (cls_d == CLS_MV_OUT) ? crn_d : cpf_addr(crd_d, idx_d);
    rd_d = rf[rd_a];
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_q <= ST_IDLE;
      cls_q <= CLS_NONE;
      dhs_q <= HS_ABSENT;
      ehs_q <= HS_ABSENT;
      rem_q <= 4'h0;
      idx_q <= 4'h0;
      crn_q <= 4'h0;
      crd_q <= 4'h0;
      crm_q <= 4'h0;
      xfer_q <= 1'b0;
      ent_q <= 1'b0;
      first_q <= 1'b0;
      wb_v_q <= 1'b0;
      wb_a_q <= 4'h0;
      wb_q <= 32'h0;
      own_q <= 1'b0;
      rd_q <= 32'h0;
      cmt_q <= 1'b0;
      abn_q <= 1'b0;
      bw_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cls_q <= cls_d;
      dhs_q <= dhs_d;
      ehs_q <= ehs_d;
      rem_q <= rem_d;
      idx_q <= idx_d;
      crn_q <= crn_d;
      crd_q <= crd_d;
      crm_q <= crm_d;
      xfer_q <= xfer_d;
      ent_q <= ent_d;
      first_q <= first_d;
      wb_v_q <= wb_v_d;
      wb_a_q <= wb_a_d;
      wb_q <= wb_d;
      own_q <= own_d;
      rd_q <= rd_d;
      cmt_q <= cmt_d;
      abn_q <= abn_d;
      bw_q <= bw_d;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (wb_v_q && !abn) begin
      rf[wb_a_q] <= wb_q;
    end
  end

  assign decode_handshake_out = dhs_q;
  assign execute_handshake_out = ehs_q;
  assign read_data_input_bus_out = rd_q;
  assign read_data_input_bus_oe_out = own_q;
  assign commit_out = cmt_q;
  assign abandon_out = abn_q;
  assign busy_wait_out = bw_q;

endmodule

// ---- rtl/cpf_decoder.sv ----
`include "cpf_consts.svh"

module cpf_decoder
  import cpf_pkg::*;
(
  input wire logic [31:0] instr_in,
  output cpf_cls_t cls_out,
  output logic mine_out,
  output logic [3:0] words_out
);

  cpf_cls_t cls;

  always_comb begin
    cls = CLS_NONE;
    words_out = `CPF_WORDS_NONE;
    if (instr_in[`CPF_OP_HI:`CPF_OP4_LO] == `CPF_OP_DATA) begin
      words_out = `CPF_WORDS_ONE;
      if (!instr_in[`CPF_MOVE_BIT]) begin
        cls = CLS_DOP;
      end else if (instr_in[`CPF_LOAD_BIT]) begin
        cls = CLS_MV_OUT;
      end else begin
        cls = CLS_MV_IN;
      end
    end else if (instr_in[`CPF_OP_HI:`CPF_OP3_LO] == `CPF_OP_LDST) begin
      cls = instr_in[`CPF_LOAD_BIT] ? CLS_LOAD : CLS_STORE;
      words_out = instr_in[`CPF_LONG_BIT] ? `CPF_WORDS_LONG : `CPF_WORDS_ONE;
    end
    mine_out = (cls != CLS_NONE) && (instr_in[`CPF_CPN_HI:`CPF_CPN_LO] == `CPF_CP_NUM);
    cls_out = cls;
  end

endmodule

// ---- rtl/cpf_follower.sv ----
module cpf_follower
  import cpf_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic fetch_request_n_in,
  input wire logic stall_input_n_in,
  input wire logic [31:0] instruction_data_bus_in,
  output logic adv_out,
  output logic [31:0] dec_instr_out
);

  logic [31:0] fet_q;
  logic [31:0] fet_d;
  logic [31:0] dec_q;
  logic [31:0] dec_d;
  logic pend_q;
  logic pend_d;

  always_comb begin
    adv_out = stall_input_n_in && !fetch_request_n_in;
    fet_d = fet_q;
    dec_d = dec_q;
    pend_d = pend_q;
    if (pend_q && stall_input_n_in) begin
      fet_d = instruction_data_bus_in;
      pend_d = 1'b0;
    end
    if (adv_out) begin
      dec_d = fet_q;
      pend_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      fet_q <= 32'h0;
      dec_q <= 32'h0;
      pend_q <= 1'b0;
    end else begin
      fet_q <= fet_d;
      dec_q <= dec_d;
      pend_q <= pend_d;
    end
  end

  assign dec_instr_out = dec_q;

endmodule

// ---- rtl/cpf_pkg.sv ----
`include "cpf_consts.svh"

package cpf_pkg;

  typedef enum logic [1:0] {
    HS_WAIT = `CPF_HS_WAIT,
    HS_GO = `CPF_HS_GO,
    HS_ABSENT = `CPF_HS_ABSENT,
    HS_LAST = `CPF_HS_LAST
  } cpf_hs_t;

  typedef enum logic [2:0] {
    CLS_NONE = 3'h0,
    CLS_DOP = 3'h1,
    CLS_MV_IN = 3'h2,
    CLS_MV_OUT = 3'h3,
    CLS_LOAD = 3'h4,
    CLS_STORE = 3'h5
  } cpf_cls_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_WAIT = 4'h2,
    ST_RUN = 4'h4,
    ST_FIN = 4'h8
  } cpf_st_t;

  // Wait while busy; otherwise go while two or more words remain, last when one remains.
  function automatic cpf_hs_t cpf_hs_pick(input logic [3:0] rem, input logic busy);
    cpf_hs_t hs;
    hs = HS_ABSENT;
    if (busy) begin
      hs = HS_WAIT;
    end else if (rem > 4'h1) begin
      hs = HS_GO;
    end else if (rem == 4'h1) begin
      hs = HS_LAST;
    end
    return hs;
  endfunction

  function automatic logic [3:0] cpf_addr(input logic [3:0] base, input logic [3:0] idx);
    return 4'(base + idx);
  endfunction

endpackage
